// File: hw/ofpc_ctrl.sv
// Notes on behaviour
// - Low supply sets power flag, fault low
// - Switch limit bit: one 2.5 A, zero 4 A
// - Pulsed mode: on interval, then 900 ms off
// - On interval 90 or 180 ms by select
// - Entering shutdown sets overload flag, fault low
// - Off then on again while overload persists
// - Clean on interval ends cycling; read clears
// - Static mode clamps and flags while overloaded
// - Overload restart mode clears voltage select bits
// - Auto restart after overload; read clears flag
// - Overtemperature disables power, sets flag, fault low
// - Thermal restart mode clears voltage select bits
// - Auto restart after overtemperature; read clears flag
// - Open-drain fault low while any flag set
// - Strap picks one of two bus addresses
// - Fault stays low until its flag clears
// - Undervoltage: ignore bus, data registers zero
`timescale 1ns/1ps
`include "ofpc_map.svh"
module ofpc_ctrl #(
  parameter int unsigned T_OFF_CYC      = `OFPC_T_OFF_MS * 1000 * `OFPC_MCLK_MHZ,
  parameter int unsigned T_ON_SHORT_CYC = `OFPC_T_ON_SHORT_MS * 1000 * `OFPC_MCLK_MHZ,
  parameter int unsigned T_ON_LONG_CYC  = `OFPC_T_ON_LONG_MS * 1000 * `OFPC_MCLK_MHZ,
  parameter int          CNT_W          = `OFPC_CNT_W
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire ofpc_pkg::ofpc_dev_t bus_dev,
  input  wire ofpc_pkg::ofpc_addr_t bus_addr,
  input  wire ofpc_pkg::ofpc_byte_t bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output ofpc_pkg::ofpc_byte_t     bus_rdata,
  input  wire logic                supply_low,
  input  wire logic                undervoltage_lockout_in,
  input  wire logic                overload_in,
  input  wire logic                overtemp_in,
  input  wire logic                addr_strap,
  output logic [3:0]               output_voltage_select,
  output logic                     output_en,
  output logic                     converter_en,
  output logic                     switch_current_limit_select,
  output logic                     comp_select,
  output logic                     fault_output_pin_out,
  output logic                     fault_output_pin_oe
);
  import ofpc_pkg::*;

  typedef struct packed {
    ofpc_ol_e   ol_st;
    logic       tripped;
    logic       seen;
    logic       ol_cause_d;
    logic       ot_d;
    logic       uv_d;
    logic       overload_flag;
    logic       overtemp_flag;
    logic       power_not_good_flag;
    logic [3:0] volt_sel;
    logic       pulsed_limit_disable;
    logic       ton_sel;
    logic       sw_lim;
    logic       comp;
    logic       overload_restart_mode;
    logic       thermal_restart_mode;
    ofpc_byte_t rdata;
  } ofpc_ctrl_s;

  ofpc_ctrl_s st_reg;
  ofpc_ctrl_s st_next;

  logic [`OFPC_SY_W-1:0] sy;
  logic                  low;
  logic                  uv;
  logic                  ovl;
  logic                  ot;
  logic                  strap;
  ofpc_dev_t             my_dev;
  logic                  acc_ok;
  logic                  wr_hit;
  logic                  rd_hit;
  logic                  rd_status;
  logic                  ol_cause;
  logic                  ol_end;
  logic                  ot_end;
  logic [CNT_W-1:0]      ton_cyc;

  // Flag held until cause gone and status read; cause wins over the read
  function automatic logic latch_flag(input logic cause, input logic flag,
                                      input logic clr);
    latch_flag = cause | (flag & ~clr);
  endfunction

  ofpc_tmr_if #(.W(CNT_W)) tmr_if ();

  ofpc_sync #(.W(`OFPC_SY_W)) u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .d_async ({addr_strap, overtemp_in, overload_in, undervoltage_lockout_in, supply_low}),
    .q       (sy)
  );

  ofpc_timer #(.CNT_W(CNT_W)) u_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tif   (tmr_if)
  );

  assign low   = sy[`OFPC_SY_LOW];
  assign uv    = sy[`OFPC_SY_UNDERVOLTAGE_LOCKOUT];
  assign ovl   = sy[`OFPC_SY_OVL];
  assign ot    = sy[`OFPC_SY_OT];
  assign strap = sy[`OFPC_SY_STRAP];

  assign my_dev    = strap ? `OFPC_DEV_ADDR_HI : `OFPC_DEV_ADDR_LO;
  assign acc_ok    = !uv && (bus_dev == my_dev);
  assign wr_hit    = bus_wr && acc_ok;
  assign rd_hit    = bus_rd && acc_ok;
  assign rd_status = rd_hit && (bus_addr == `OFPC_REG_STATUS);

  assign ton_cyc = st_reg.ton_sel ? CNT_W'(T_ON_LONG_CYC) : CNT_W'(T_ON_SHORT_CYC);
  assign ol_cause = st_reg.pulsed_limit_disable ? ovl : st_reg.tripped;
  assign ol_end   = st_reg.ol_cause_d && !ol_cause;
  assign ot_end   = st_reg.ot_d && !ot;

  always_comb begin
    st_next       = st_reg;
    tmr_if.start  = 1'b0;
    tmr_if.load   = ton_cyc;
    st_next.rdata = 8'h00;
    // Pulsed overload limiting
    if (st_reg.pulsed_limit_disable) begin
      st_next.ol_st   = OL_NORMAL;
      st_next.tripped = 1'b0;
      st_next.seen    = 1'b0;
    end else begin
      unique case (st_reg.ol_st)
        OL_NORMAL: begin
          if (ovl) begin
            st_next.ol_st = OL_ON;
            st_next.seen  = 1'b1;
            tmr_if.start  = 1'b1;
          end
        end
        OL_ON: begin
          st_next.seen = st_reg.seen | ovl;
          if (tmr_if.done) begin
            if (st_reg.seen | ovl) begin
              st_next.ol_st   = OL_OFF;
              st_next.tripped = 1'b1;
              tmr_if.start    = 1'b1;
              tmr_if.load     = CNT_W'(T_OFF_CYC);
            end else begin
              st_next.ol_st   = OL_NORMAL;
              st_next.tripped = 1'b0;
            end
          end
        end
        OL_OFF: begin
          if (tmr_if.done) begin
            st_next.ol_st = OL_ON;
            st_next.seen  = 1'b0;
            tmr_if.start  = 1'b1;
          end
        end
      endcase
    end
    st_next.ol_cause_d = ol_cause;
    st_next.ot_d       = ot;
    st_next.uv_d       = uv;
    // Diagnostic flags
    st_next.overload_flag = latch_flag(ol_cause, st_reg.overload_flag, rd_status);
    st_next.overtemp_flag = latch_flag(ot, st_reg.overtemp_flag, rd_status);
    st_next.power_not_good_flag =
      latch_flag(low, st_reg.power_not_good_flag, rd_status);
    // Register writes
    if (wr_hit) begin
      unique case (bus_addr)
        `OFPC_REG_VOLT: st_next.volt_sel = bus_wdata[3:0];
        `OFPC_REG_LIMIT: begin
          st_next.pulsed_limit_disable = bus_wdata[`OFPC_LIM_PULSE_DIS];
          st_next.ton_sel              = bus_wdata[`OFPC_LIM_TON_SEL];
        end
        `OFPC_REG_CONV: begin
          st_next.sw_lim                = bus_wdata[`OFPC_CONV_SW_LIM];
          st_next.comp                  = bus_wdata[`OFPC_CONV_COMP];
          st_next.overload_restart_mode = bus_wdata[`OFPC_CONV_OVL_RST];
          st_next.thermal_restart_mode  = bus_wdata[`OFPC_CONV_OT_RST];
        end
        default: begin
        end
      endcase
    end
    // Manual restart drops the voltage select, winning over a write
    if ((st_reg.overload_restart_mode && ol_end) ||
        (st_reg.thermal_restart_mode && ot_end)) begin
      st_next.volt_sel = 4'h0;
    end
    // Register reads
    if (rd_hit) begin
      unique case (bus_addr)
        `OFPC_REG_STATUS: begin
          st_next.rdata[`OFPC_STS_OVL_FLAG] = st_reg.overload_flag;
          st_next.rdata[`OFPC_STS_OT_FLAG]  = st_reg.overtemp_flag;
          st_next.rdata[`OFPC_STS_PWR_BAD]  = st_reg.power_not_good_flag;
          st_next.rdata[`OFPC_STS_OVL_LIVE] = ovl;
          st_next.rdata[`OFPC_STS_SHUTDOWN] = (st_reg.ol_st == OL_OFF);
        end
        `OFPC_REG_VOLT: st_next.rdata = {4'h0, st_reg.volt_sel};
        `OFPC_REG_LIMIT: begin
          st_next.rdata[`OFPC_LIM_PULSE_DIS] = st_reg.pulsed_limit_disable;
          st_next.rdata[`OFPC_LIM_TON_SEL]   = st_reg.ton_sel;
        end
        `OFPC_REG_CONV: begin
          st_next.rdata[`OFPC_CONV_SW_LIM]  = st_reg.sw_lim;
          st_next.rdata[`OFPC_CONV_COMP]    = st_reg.comp;
          st_next.rdata[`OFPC_CONV_OVL_RST] = st_reg.overload_restart_mode;
          st_next.rdata[`OFPC_CONV_OT_RST]  = st_reg.thermal_restart_mode;
        end
        default: st_next.rdata = 8'h00;
      endcase
    end
    // Undervoltage holds every data register at zero
    if (uv) begin
      st_next.volt_sel              = 4'h0;
      st_next.pulsed_limit_disable  = 1'b0;
      st_next.ton_sel               = 1'b0;
      st_next.sw_lim                = 1'b0;
      st_next.comp                  = 1'b0;
      st_next.overload_restart_mode = 1'b0;
      st_next.thermal_restart_mode  = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata                   = st_reg.rdata;
  assign output_voltage_select       = st_reg.volt_sel;
  assign switch_current_limit_select = st_reg.sw_lim;
  assign comp_select                 = st_reg.comp;
  assign converter_en                = !st_reg.uv_d && !st_reg.ot_d;
  assign output_en = converter_en && (st_reg.volt_sel != 4'h0) &&
                     (st_reg.ol_st != OL_OFF);
  assign fault_output_pin_out = 1'b0;
  assign fault_output_pin_oe  = st_reg.overload_flag | st_reg.overtemp_flag |
                                st_reg.power_not_good_flag;

  // Checks
  chk_pwr_bad_fault: assert property (@(posedge mclk) disable iff (!rst_n)
    low |=> (st_reg.power_not_good_flag && fault_output_pin_oe))
    else $error("power flag or fault not set on low supply");

  chk_sw_limit_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_hit && bus_addr == `OFPC_REG_CONV && !uv)
      |=> (switch_current_limit_select == $past(bus_wdata[`OFPC_CONV_SW_LIM])))
    else $error("switch limit select not taken from write");

  chk_on_load: assert property (@(posedge mclk) disable iff (!rst_n)
    (tmr_if.start && st_next.ol_st == OL_ON) |->
      (tmr_if.load == (st_reg.ton_sel ? CNT_W'(T_ON_LONG_CYC) : CNT_W'(T_ON_SHORT_CYC))))
    else $error("on interval length wrong");

  chk_off_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.ol_st == OL_ON && tmr_if.done && (st_reg.seen || ovl) && !st_reg.pulsed_limit_disable)
      |=> (st_reg.ol_st == OL_OFF && !output_en && tmr_if.load == CNT_W'(T_OFF_CYC))
      or (st_reg.ol_st == OL_OFF && !output_en))
    else $error("shutdown not entered after overloaded on interval");

  chk_off_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.ol_st == OL_OFF && !st_reg.pulsed_limit_disable) |=>
      (st_reg.overload_flag && fault_output_pin_oe))
    else $error("overload flag missing during shutdown");

  chk_retry: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.ol_st == OL_OFF && tmr_if.done && !st_reg.pulsed_limit_disable)
      |=> (st_reg.ol_st == OL_ON && !st_reg.seen))
    else $error("no retry after off interval");

  chk_clean_exit: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.ol_st == OL_ON && tmr_if.done && !st_reg.seen && !ovl)
      |=> (st_reg.ol_st == OL_NORMAL && !st_reg.tripped))
    else $error("clean on interval did not end cycling");

  chk_static_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.pulsed_limit_disable && ovl) |=> (st_reg.overload_flag && fault_output_pin_oe))
    else $error("static clamp did not flag overload");

  chk_ovl_rst_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.overload_restart_mode && ol_end) |=> (output_voltage_select == 4'h0))
    else $error("voltage select kept after overload in manual restart");

  chk_ot_rst_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.thermal_restart_mode && ot_end) |=> (output_voltage_select == 4'h0))
    else $error("voltage select kept after overtemperature in manual restart");

  chk_ot_shut: assert property (@(posedge mclk) disable iff (!rst_n)
    ot |=> (!converter_en && !output_en && st_reg.overtemp_flag))
    else $error("overtemperature did not shut power");

  chk_flag_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (fault_output_pin_oe && !rd_status) |=> fault_output_pin_oe)
    else $error("fault released without a status read");

  chk_undervoltage_lockout_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    uv |=> (output_voltage_select == 4'h0 && bus_rdata == 8'h00 && !converter_en))
    else $error("undervoltage did not hold registers at zero");
endmodule

// File: inc/ofpc_map.svh
`ifndef OFPC_MAP_SVH
`define OFPC_MAP_SVH

// Register offsets
`define OFPC_REG_STATUS    3'h0
`define OFPC_REG_VOLT      3'h1
`define OFPC_REG_LIMIT     3'h2
`define OFPC_REG_CONV      3'h3

// Status fields
`define OFPC_STS_OVL_FLAG  0
`define OFPC_STS_OT_FLAG   1
`define OFPC_STS_PWR_BAD   2
`define OFPC_STS_OVL_LIVE  3
`define OFPC_STS_SHUTDOWN  4

// Limit register fields
`define OFPC_LIM_PULSE_DIS 0
`define OFPC_LIM_TON_SEL   1

// Converter register fields
`define OFPC_CONV_SW_LIM   0
`define OFPC_CONV_COMP     1
`define OFPC_CONV_OVL_RST  2
`define OFPC_CONV_OT_RST   3

// Reset value of every data register
`define OFPC_DATA_RST      8'h00

// Serial bus addresses picked by the strap
`define OFPC_DEV_ADDR_LO   7'h08
`define OFPC_DEV_ADDR_HI   7'h09

// Timing
`define OFPC_MCLK_MHZ      250
`define OFPC_T_OFF_MS      900
`define OFPC_T_ON_SHORT_MS 90
`define OFPC_T_ON_LONG_MS  180
`define OFPC_CNT_W         28

// Synchroniser lanes
`define OFPC_SY_LOW        0
`define OFPC_SY_UNDERVOLTAGE_LOCKOUT       1
`define OFPC_SY_OVL        2
`define OFPC_SY_OT         3
`define OFPC_SY_STRAP      4
`define OFPC_SY_W          5

`endif

// File: inc/ofpc_pkg.sv
package ofpc_pkg;
  typedef enum {OL_NORMAL, OL_ON, OL_OFF} ofpc_ol_e;
  typedef logic [7:0] ofpc_byte_t;
  typedef logic [2:0] ofpc_addr_t;
  typedef logic [6:0] ofpc_dev_t;
endpackage

// File: inc/ofpc_tmr_if.sv
`timescale 1ns/1ps
interface ofpc_tmr_if #(parameter int W = 28);
  logic         start;
  logic [W-1:0] load;
  logic         done;
  modport ctrl (output start, output load, input done);
  modport tmr  (input start, input load, output done);
endinterface

// File: hw/ofpc_sync.sv
`timescale 1ns/1ps
module ofpc_sync #(
  parameter int W = 5
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ofpc_sync_s;

  ofpc_sync_s st_reg;
  ofpc_sync_s st_next;

  always_comb begin
    st_next.s1 = d_async;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule

// File: hw/ofpc_timer.sv
`timescale 1ns/1ps
module ofpc_timer #(
  parameter int CNT_W = 28
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  ofpc_tmr_if.tmr   tif
);
  typedef struct packed {
    logic             busy;
    logic [CNT_W-1:0] cnt;
  } ofpc_tmr_s;

  ofpc_tmr_s st_reg;
  ofpc_tmr_s st_next;

  // Interval ends load cycles after the start cycle
  always_comb begin
    st_next = st_reg;
    if (tif.start) begin
      st_next.busy = 1'b1;
      st_next.cnt  = tif.load;
    end else if (st_reg.busy) begin
      if (st_reg.cnt <= CNT_W'(1)) begin
        st_next.busy = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tif.done = st_reg.busy && (st_reg.cnt <= CNT_W'(1));
endmodule

// File: verification/ofpc_host_model.sv
`timescale 1ns/1ps
module ofpc_host_model (
  input  wire logic                 mclk,
  output ofpc_pkg::ofpc_dev_t       bus_dev,
  output ofpc_pkg::ofpc_addr_t      bus_addr,
  output ofpc_pkg::ofpc_byte_t      bus_wdata,
  output logic                      bus_wr,
  output logic                      bus_rd,
  input  wire ofpc_pkg::ofpc_byte_t bus_rdata
);
  import ofpc_pkg::*;
  ofpc_dev_t dev_sel = 7'h08;
  assign bus_dev = dev_sel;
  initial begin
    bus_addr = 3'h0;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // One-cycle write strobe beside address and data
  task automatic wr(input ofpc_addr_t a, input ofpc_byte_t d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  // Data taken in the cycle after the read strobe
  task automatic rd(input ofpc_addr_t a, output ofpc_byte_t d);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "ofpc_map.svh"
module tb_top;
  import ofpc_pkg::*;
  localparam int TOFF = 90;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_low = 1'b0;
  logic undervoltage_lockout_in = 1'b0;
  logic overload_in = 1'b0;
  logic overtemp_in = 1'b0;
  logic addr_strap = 1'b0;
  ofpc_dev_t dev;
  ofpc_addr_t addr;
  ofpc_byte_t wdata;
  ofpc_byte_t rdata;
  ofpc_byte_t d;
  logic wr;
  logic rd;
  logic [3:0] volt;
  logic oen;
  logic cen;
  logic sw_lim;
  logic comp;
  logic fault_pin;
  logic fault_oe;
  int err_total = 0;
  int checks_done = 0;
  int n;
  int ton;

  always #2 mclk = ~mclk;

  ofpc_ctrl #(.T_OFF_CYC(TOFF), .T_ON_SHORT_CYC(9), .T_ON_LONG_CYC(18)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .bus_dev(dev), .bus_addr(addr), .bus_wdata(wdata),
    .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata), .supply_low(supply_low),
    .undervoltage_lockout_in(undervoltage_lockout_in), .overload_in(overload_in), .overtemp_in(overtemp_in),
    .addr_strap(addr_strap), .output_voltage_select(volt), .output_en(oen),
    .converter_en(cen), .switch_current_limit_select(sw_lim), .comp_select(comp),
    .fault_output_pin_out(fault_pin), .fault_output_pin_oe(fault_oe)
  );

  ofpc_host_model u_host (
    .mclk(mclk), .bus_dev(dev), .bus_addr(addr), .bus_wdata(wdata),
    .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata)
  );

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic rdchk(input string nm, input ofpc_addr_t a, input ofpc_byte_t exp);
    ofpc_byte_t v;
    u_host.rd(a, v);
    chk(nm, v, exp);
  endtask

  // Counts cycles until output enable reaches the given level
  task automatic wait_oen(input logic lvl);
    n = 0;
    while (oen !== lvl && n < 400) begin
      tick(1);
      n++;
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #80000;
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge mclk);
    @(posedge mclk) rst_n <= 1'b1;
    tick(3);
    chk("fault_oe_rst", 8'(fault_oe), 8'h00);
    for (int a = 0; a < 6; a++) begin
      rdchk("reg_rst", 3'(a), `OFPC_DATA_RST);
    end
    u_host.wr(`OFPC_REG_VOLT, 8'h0F);
    u_host.wr(`OFPC_REG_CONV, 8'h01);
    tick(1);
    chk("sw_lim_one", 8'({sw_lim, comp}), 8'h02);
    u_host.wr(`OFPC_REG_CONV, 8'h02);
    tick(1);
    chk("sw_lim_zero", 8'({sw_lim, comp}), 8'h01);
    u_host.wr(`OFPC_REG_CONV, 8'h00);
    tick(1);
    chk("out_on", 8'({oen, cen, volt}), 8'h3F);
    // Supply low diagnostic
    @(posedge mclk) supply_low <= 1'b1;
    tick(5);
    chk("pwr_bad_fault", 8'(fault_oe), 8'h01);
    chk("fault_pin_low", 8'(fault_pin), 8'h00);
    @(posedge mclk) supply_low <= 1'b0;
    tick(5);
    chk("pwr_bad_held", 8'(fault_oe), 8'h01);
    rdchk("pwr_bad_read", `OFPC_REG_STATUS, 8'h04);
    tick(2);
    chk("pwr_bad_off", 8'(fault_oe), 8'h00);
    rdchk("pwr_bad_clear", `OFPC_REG_STATUS, 8'h00);
    // Pulsed limiting for both on-interval selections
    for (int s = 0; s < 2; s++) begin
      ton = (s == 1) ? 18 : 9;
      u_host.wr(`OFPC_REG_LIMIT, {6'h00, s[0], 1'b0});
      @(posedge mclk) overload_in <= 1'b1;
      wait_oen(1'b0);
      chk("ton_len", 8'(n >= ton && n <= ton + 4), 8'h01);
      tick(2);
      chk("ovl_fault", 8'(fault_oe), 8'h01);
      wait_oen(1'b1);
      chk("toff_len", 8'(n >= TOFF - 3 && n <= TOFF + 1), 8'h01);
      @(posedge mclk) overload_in <= 1'b0;
      wait_oen(1'b0);
      chk("repeat_off", 8'(n <= ton + 2), 8'h01);
      wait_oen(1'b1);
      tick(ton + 6);
      chk("normal_on", 8'({oen, volt}), 8'h1F);
      chk("fault_kept", 8'(fault_oe), 8'h01);
      rdchk("ovl_read", `OFPC_REG_STATUS, 8'h01);
      rdchk("ovl_clear", `OFPC_REG_STATUS, 8'h00);
      chk("fault_clear", 8'(fault_oe), 8'h00);
    end
    // Static clamp with manual restart
    u_host.wr(`OFPC_REG_LIMIT, 8'h01);
    u_host.wr(`OFPC_REG_CONV, 8'h04);
    @(posedge mclk) overload_in <= 1'b1;
    tick(5);
    chk("clamp_fault", 8'({oen, fault_oe}), 8'h03);
    rdchk("clamp_status", `OFPC_REG_STATUS, 8'h09);
    @(posedge mclk) overload_in <= 1'b0;
    tick(5);
    chk("man_rst_volt", 8'({oen, volt}), 8'h00);
    rdchk("man_rst_read", `OFPC_REG_STATUS, 8'h01);
    rdchk("man_rst_clear", `OFPC_REG_STATUS, 8'h00);
    u_host.wr(`OFPC_REG_VOLT, 8'h0F);
    tick(1);
    chk("man_rst_back", 8'(oen), 8'h01);
    // Overtemperature, manual then automatic restart
    for (int t = 0; t < 2; t++) begin
      u_host.wr(`OFPC_REG_CONV, (t == 0) ? 8'h08 : 8'h00);
      @(posedge mclk) overtemp_in <= 1'b1;
      tick(5);
      chk("ot_off", 8'({cen, oen, fault_oe}), 8'h01);
      @(posedge mclk) overtemp_in <= 1'b0;
      tick(5);
      chk("ot_restart", 8'({oen, volt}), (t == 0) ? 8'h00 : 8'h1F);
      rdchk("ot_read", `OFPC_REG_STATUS, 8'h02);
      rdchk("ot_clear", `OFPC_REG_STATUS, 8'h00);
      u_host.wr(`OFPC_REG_VOLT, 8'h0F);
    end
    // Address strap
    @(posedge mclk) addr_strap <= 1'b1;
    tick(4);
    u_host.wr(`OFPC_REG_VOLT, 8'h05);
    rdchk("dev_wrong", `OFPC_REG_VOLT, 8'h00);
    @(posedge mclk) u_host.dev_sel <= `OFPC_DEV_ADDR_HI;
    rdchk("dev_strap", `OFPC_REG_VOLT, 8'h0F);
    // Undervoltage lockout
    @(posedge mclk) undervoltage_lockout_in <= 1'b1;
    tick(5);
    chk("undervoltage_lockout_out", 8'({cen, oen, volt}), 8'h00);
    u_host.wr(`OFPC_REG_VOLT, 8'h03);
    rdchk("undervoltage_lockout_rd", `OFPC_REG_VOLT, 8'h00);
    @(posedge mclk) undervoltage_lockout_in <= 1'b0;
    tick(5);
    rdchk("undervoltage_lockout_zero", `OFPC_REG_VOLT, 8'h00);
    wrap_up();
  end
endmodule
